// *** hw/smd_params.svh ***
`ifndef SMD_PARAMS_SVH
`define SMD_PARAMS_SVH
// Data width of the file registers and accumulator
`define SMD_DATA_W 8
// Width of the file register address field
`define SMD_ADDR_W 7
// Reset values
`define SMD_W_RESET 8'h00
`define SMD_FLAG_RESET 1'b0
// Destination bit encodings
`define SMD_DEST_W 1'b0
`define SMD_DEST_F 1'b1
`endif

// *** hw/smd_pkg.sv ***
package smd_pkg;
  // Operation selected by the decoder
  typedef enum logic [1:0] {
    SMD_OP_NONE = 2'b00,
    SMD_OP_SHL  = 2'b01,
    SMD_OP_SHR  = 2'b10,
    SMD_OP_MOV  = 2'b11
  } smd_op_e;

  // Request from the decoder
  typedef struct packed {
    smd_op_e    op;
    logic       dest;
    logic [6:0] addr;
    logic [7:0] data;
  } smd_req_s;

  // Write-back to file register space
  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] data;
  } smd_fwr_s;
endpackage : smd_pkg

// *** hw/smd_alu.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "smd_params.svh"
// ***************************************************
// Combinational shift and move unit
// ***************************************************
module smd_alu (
  input  wire smd_pkg::smd_op_e op,
  input  wire logic [7:0]       src,
  input  wire logic             carry_in,
  output logic [7:0]            result,
  output logic                  carry_out,
  output logic                  zero_out
);
  // Result and carry per operation
  always_comb begin
    result    = src;
    carry_out = carry_in;
    case (op)
      smd_pkg::SMD_OP_SHL: begin
        result    = {src[6:0], 1'b0};
        carry_out = src[7];
      end
      smd_pkg::SMD_OP_SHR: begin
        result    = {1'b0, src[7:1]};
        carry_out = src[0];
      end
      smd_pkg::SMD_OP_MOV: begin
        result    = src;
        carry_out = carry_in;
      end
      default: begin
        result    = src;
        carry_out = carry_in;
      end
    endcase
    zero_out = (result == 8'h00);
  end
endmodule // smd_alu
`default_nettype wire

// *** hw/smd_datapath.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "smd_params.svh"
// ***************************************************
// Shift and move datapath slice
// ***************************************************
// Operation
// - Left shift: bit 7 to carry, bits 6..0 up one, zero in bit 0.
// - Right shift: zero into bit 7, bits 7..1 down one, bit 0 to carry.
// - Shift result goes to accumulator when dest is 0, to register if 1.
// - Move copies register unchanged to accumulator or back to itself.
// - Move updates zero flag, so write-back tests a register.
module smd_datapath (
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic              clk_en,
  input  wire smd_pkg::smd_req_s req,
  output smd_pkg::smd_fwr_s      fwr,
  output logic [7:0]             w_reg,
  output logic                   carry_flag,
  output logic                   zero_flag
);
  // ***************************************************
  // Reset synchroniser
  // ***************************************************
  logic [1:0] rst_sync;
  logic       rst_b_int;

  // Asynchronous assert, synchronous release
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_b_int = rst_sync[1];

  // ***************************************************
  // Compute
  // ***************************************************
  logic [7:0] alu_result;
  logic       alu_carry;
  logic       alu_zero;

  smd_alu u_alu (
    .op        (req.op),
    .src       (req.data),
    .carry_in  (carry_flag),
    .result    (alu_result),
    .carry_out (alu_carry),
    .zero_out  (alu_zero)
  );

  // ***************************************************
  // State update
  // ***************************************************
  smd_pkg::smd_fwr_s next_fwr;
  logic [7:0]        next_w_reg;
  logic              next_carry_flag;
  logic              next_zero_flag;
  logic              active;

  // Next-state steering; idle cycles hold every flag
  always_comb begin
    active          = (req.op != smd_pkg::SMD_OP_NONE);
    next_w_reg      = w_reg;
    next_carry_flag = carry_flag;
    next_zero_flag  = zero_flag;
    next_fwr        = '0;
    if (active) begin
      next_carry_flag = alu_carry;
      next_zero_flag  = alu_zero;
      if (req.dest == `SMD_DEST_F) begin
        next_fwr.we   = 1'b1;
        next_fwr.addr = req.addr;
        next_fwr.data = alu_result;
      end else begin
        next_w_reg    = alu_result;
      end
    end
  end

  // Registers only; clock enable freezes all state
  always_ff @(posedge core_clk or negedge rst_b_int) begin
    if (!rst_b_int) begin
      w_reg      <= `SMD_W_RESET;
      carry_flag <= `SMD_FLAG_RESET;
      zero_flag  <= `SMD_FLAG_RESET;
      fwr        <= '0;
    end else if (clk_en) begin
      w_reg      <= next_w_reg;
      carry_flag <= next_carry_flag;
      zero_flag  <= next_zero_flag;
      fwr        <= next_fwr;
    end
  end

  // ***************************************************
  // Assertions
  // ***************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b_int);

  logic go;
  assign go = clk_en && active;

  // Zero test shared by the two accumulator zero flag checks below
  function automatic logic is_zero(input logic [7:0] v);
    return (v == 8'h00);
  endfunction

  // ***************************************************
  // Routes not covered by the checks further down, apart from the two write-back address checks
  // ***************************************************
  // Left shift written back carries the same pattern as into W
  AST_SHL_WB: assert property (
    go && req.op == smd_pkg::SMD_OP_SHL && req.dest
    |=> fwr.we && fwr.data == {$past(req.data[6:0]), 1'b0})
    else $error("left shift write-back wrong");

  // Right shift into the accumulator
  AST_SHR_W: assert property (
    go && req.op == smd_pkg::SMD_OP_SHR && !req.dest
    |=> w_reg == {1'b0, $past(req.data[7:1])})
    else $error("right shift accumulator wrong");

  // Write-back must land on the source register, not a neighbour
  AST_SHL_WB_ADDR: assert property (
    go && req.op == smd_pkg::SMD_OP_SHL && req.dest
    |=> fwr.we && fwr.addr == $past(req.addr))
    else $error("left shift write-back address wrong");

  AST_MOV_F_ADDR: assert property (
    go && req.op == smd_pkg::SMD_OP_MOV && req.dest
    |=> fwr.we && fwr.addr == $past(req.addr) && $stable(w_reg))
    else $error("move write-back address wrong");

  // Zero flag of a move to W follows the moved byte
  AST_MOV_ZERO_W: assert property (
    go && req.op == smd_pkg::SMD_OP_MOV && !req.dest
    |=> zero_flag == is_zero($past(req.data)))
    else $error("move zero flag wrong");

  // Zero flag of any accumulator result
  AST_ZERO_W: assert property (
    go && !req.dest |=> zero_flag == is_zero(w_reg))
    else $error("accumulator zero flag wrong");

  // Zero flag from the operand bits that survive each shift
  AST_SHL_Z: assert property (
    go && req.op == smd_pkg::SMD_OP_SHL
    |=> zero_flag == ($past(req.data[6:0]) == 7'h00))
    else $error("left shift zero flag wrong");

  AST_SHR_Z: assert property (
    go && req.op == smd_pkg::SMD_OP_SHR
    |=> zero_flag == ($past(req.data[7:1]) == 7'h00))
    else $error("right shift zero flag wrong");

  // Frozen enable holds W, carry and a pending write pulse too
  AST_FREEZE: assert property (
    !clk_en |=> $stable(w_reg) && $stable(carry_flag) && $stable(fwr))
    else $error("state moved while frozen");

  // Write pulse lasts one enabled cycle unless a new write follows
  AST_WE_PULSE: assert property (
    fwr.we && clk_en && !go |=> !fwr.we)
    else $error("write pulse stretched");

  // Idle slots leave flags and accumulator alone
  AST_IDLE_HOLD: assert property (
    clk_en && !active
    |=> $stable(w_reg) && $stable(carry_flag) && $stable(zero_flag))
    else $error("idle slot changed state");

  AST_SHL_CARRY: assert property (
    go && req.op == smd_pkg::SMD_OP_SHL |=> carry_flag == $past(req.data[7]))
    else $error("left shift carry wrong");
  AST_SHL_RES: assert property (
    go && req.op == smd_pkg::SMD_OP_SHL && !req.dest
    |=> w_reg == {$past(req.data[6:0]), 1'b0})
    else $error("left shift result wrong");
  AST_SHR_CARRY: assert property (
    go && req.op == smd_pkg::SMD_OP_SHR |=> carry_flag == $past(req.data[0]))
    else $error("right shift carry wrong");
  AST_SHR_RES: assert property (
    go && req.op == smd_pkg::SMD_OP_SHR && req.dest
    |=> fwr.we && fwr.data == {1'b0, $past(req.data[7:1])})
    else $error("right shift result wrong");
  AST_DEST_F_KEEPS_W: assert property (
    go && req.dest |=> $stable(w_reg) && fwr.addr == $past(req.addr))
    else $error("register destination disturbed accumulator");
  AST_DEST_W_NO_WB: assert property (
    go && !req.dest |=> !fwr.we)
    else $error("accumulator destination wrote register");
  AST_MOV_COPY: assert property (
    go && req.op == smd_pkg::SMD_OP_MOV && !req.dest
    |=> w_reg == $past(req.data))
    else $error("move altered value");
  AST_MOV_TEST: assert property (
    go && req.op == smd_pkg::SMD_OP_MOV && req.dest
    |=> fwr.data == $past(req.data) && zero_flag == ($past(req.data) == 8'h00))
    else $error("move test wrong");
  AST_MOV_CARRY: assert property (
    go && req.op == smd_pkg::SMD_OP_MOV |=> $stable(carry_flag))
    else $error("move changed carry");
  AST_ZERO: assert property (
    go && req.dest |=> zero_flag == (fwr.data == 8'h00))
    else $error("zero flag mismatch");

  COV_SHL: cover property (go && req.op == smd_pkg::SMD_OP_SHL);
  COV_SHR_F: cover property (go && req.op == smd_pkg::SMD_OP_SHR && req.dest);
  COV_MOV_ZERO: cover property (
    go && req.op == smd_pkg::SMD_OP_MOV && req.data == 8'h00);
  COV_BACK2BACK: cover property (go ##1 go);
  COV_FREEZE: cover property (!clk_en && active);
endmodule // smd_datapath
`default_nettype wire

// *** dv/smd_freg_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ***************************************************
// File register space seen by the slice
// ***************************************************
module smd_freg_model (
  input  wire logic              core_clk,
  input  wire logic [6:0]        addr,
  input  wire smd_pkg::smd_fwr_s fwr,
  output logic [7:0]             data
);
  logic [7:0] mem [128];
  // Preset so that 01, 82, 40 and 83 sit at 1, 2, 40h and 3
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = {i[1], i[6:0]};
    end
  end
  // Write-back takes effect at the edge after the pulse is seen
  always @(posedge core_clk) begin
    if (fwr.we) begin
      mem[fwr.addr] <= fwr.data;
    end
  end
  assign data = mem[addr];
endmodule // smd_freg_model
`default_nettype wire

// *** dv/tb_shift_and_move_datapath.sv ***
`timescale 1ns/1ps
`default_nettype none
// ***************************************************
// Bench for the shift and move slice
// ***************************************************
module tb_shift_and_move_datapath;
  logic              core_clk;
  logic              rst_b;
  logic              clk_en;
  smd_pkg::smd_op_e  op;
  logic              dest;
  logic [6:0]        addr;
  logic [7:0]        f_data;
  smd_pkg::smd_req_s req;
  smd_pkg::smd_fwr_s fwr;
  logic [7:0]        w_reg;
  logic              carry_flag;
  logic              zero_flag;
  logic [7:0]        exp_w;
  logic              exp_c;
  logic              exp_z;
  int                n_fail = 0;
  int                checked = 0;
  int                cycles = 0;
  assign req = {op, dest, addr, f_data};
  smd_datapath i_dut (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
    .req(req), .fwr(fwr), .w_reg(w_reg), .carry_flag(carry_flag),
    .zero_flag(zero_flag));
  smd_freg_model i_freg (.core_clk(core_clk), .addr(addr), .fwr(fwr),
    .data(f_data));
  // Clock and hang guard; the run needs well under 200 cycles
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_fail++;
      complete_run();
    end
  end
  function automatic logic [25:0] state();
    return {w_reg, carry_flag, zero_flag, fwr};
  endfunction
  task automatic chk(input string s, input logic [25:0] e, g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  // One instruction, then its pulse drop and write-back
  task automatic issue(input smd_pkg::smd_op_e o, input logic d,
                       input logic [6:0] a);
    logic [7:0] res;
    logic [7:0] src;
    @(negedge core_clk);
    op = o;
    dest = d;
    addr = a;
    #1;
    src = f_data;
    res = f_data;
    case (o)
      smd_pkg::SMD_OP_SHL: {exp_c, res} = {f_data, 1'b0};
      smd_pkg::SMD_OP_SHR: {res, exp_c} = {1'b0, f_data};
      default: ; // Move keeps carry
    endcase
    exp_z = (res == 8'h00);
    if (!d) exp_w = res;
    @(negedge core_clk);
    chk("out", {exp_w, exp_c, exp_z, d, {15{d}} & {a, res}}, state());
    op = smd_pkg::SMD_OP_NONE;
    @(negedge core_clk);
    chk("drop", {exp_w, exp_c, exp_z, 16'h0000}, state());
    // Accumulator results leave the source register as it was
    chk("file", {18'h0_0000, d ? res : src}, {18'h0_0000, f_data});
  endtask
  task automatic t_shift_right();
    issue(smd_pkg::SMD_OP_SHR, 1'b1, 7'h01);
    issue(smd_pkg::SMD_OP_SHR, 1'b0, 7'h02);
  endtask
  task automatic t_shift_left();
    issue(smd_pkg::SMD_OP_SHL, 1'b0, 7'h02);
    issue(smd_pkg::SMD_OP_SHL, 1'b1, 7'h40);
    issue(smd_pkg::SMD_OP_SHL, 1'b0, 7'h40);
  endtask
  task automatic t_move();
    issue(smd_pkg::SMD_OP_MOV, 1'b1, 7'h01);
    issue(smd_pkg::SMD_OP_MOV, 1'b0, 7'h03);
  endtask
  // Frozen enable, then an idle slot: nothing may move
  task automatic t_refuse();
    @(negedge core_clk);
    op = smd_pkg::SMD_OP_SHL;
    clk_en = 1'b0;
    @(negedge core_clk);
    chk("frozen", {exp_w, exp_c, exp_z, 16'h0000}, state());
    clk_en = 1'b1;
    op = smd_pkg::SMD_OP_NONE;
    @(negedge core_clk);
    chk("idle", {exp_w, exp_c, exp_z, 16'h0000}, state());
  endtask
  task automatic complete_run();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    op = smd_pkg::SMD_OP_NONE;
    dest = 1'b0;
    addr = 7'h00;
    {exp_w, exp_c, exp_z} = 10'h000;
    repeat (16) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (3) @(negedge core_clk);
    chk("reset", 26'h000_0000, state());
    t_shift_right();
    t_shift_left();
    t_move();
    t_refuse();
    complete_run();
  end
endmodule // tb_shift_and_move_datapath
`default_nettype wire
